// ### core/otg_rx_pkg.sv
// Constants for the transceiver receive path and power control.
// Assumes a single 25 MHz system clock.
package otg_rx_pkg;
    localparam int unsigned CLK_MHZ = 25;
    localparam int unsigned RESET_PULSE_NS = 200;
    localparam int unsigned DIP_FILTER_US = 11;
    // Pulse width rounds down, at least one cycle
    localparam int unsigned RESET_PULSE_CYCLES_RAW = RESET_PULSE_NS * CLK_MHZ / 1000;
    localparam int unsigned RESET_PULSE_CYCLES =
        (RESET_PULSE_CYCLES_RAW < 1) ? 1 : RESET_PULSE_CYCLES_RAW;
    // Dip must exceed this many cycles before a new pulse
    localparam int unsigned DIP_CYCLES = DIP_FILTER_US * CLK_MHZ;
    localparam int unsigned CNT_W = 9;
    localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;
    localparam logic [6:0] BUS_ADDR_BASE = 7'h2C;
    localparam logic ADDR_BIT_RESET = 1'h0;
    localparam logic HOLD_RESET = 1'h0;
    localparam int unsigned BUF_DEPTH = 2;
    localparam int unsigned BUF_W = 3;
endpackage

// ### core/otg_rx_power.sv
// Receive-side line decoding, power-on reset pulse and pump switch control.
// Line and supply-detect inputs are asynchronous and pass three flip-flops.
//
// Contract
// - Enable high, no suspend, single-data mode: receiver result on data and receive.
// - Enable high, no suspend, split mode: receiver result only on receive pin.
// - Single-data, no suspend: zero flag high only for both lines low.
// - Single-data, no suspend, equal lines: receive holds, data copies it.
// - Split mode: plus from DP, minus from DM; receive holds on equal lines.
// - Suspend powers receiver down; data follows DP, zero flag on SE0.
// - Internal active-high reset pulse, about 200 ns, when supply rises.
// - Reset starts low; delay stretches by one pulse width, then low.
// - Regenerate pulse after dips over 11 us; ignore shorter dips.
// - Latch address/switch pin level on rising edge of external reset.
// - Bus address is 2Ch for bit 0, 2Dh for bit 1.
// - Latched address bit is zero after power-on reset.
// - Pump switch active high for bit 0, active low for bit 1.
// - Pump switch driven only while its enable bit is 1.
// - Without external reset pulse, pump switch polarity is active high.
// - Power-down bit stops clocking and bias; zero means full operation.
// - No I/O supply with core supply: power down, driver tri-stated.
// - No core supply: stable digital outputs, bidirectional pins tri-stated.
// - Split mode, enable high: plus and minus carry single-ended receivers.
// - Single-data mode: data and zero flag pins used, receive also carries the receiver result.
`timescale 1ns/1ns
module otg_rx_power (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic dp_in,
    input wire logic dm_in,
    input wire logic output_enable_in,
    input wire logic suspend_bit_in,
    input wire logic single_data_mode_bit_in,
    input wire logic power_down_bit_in,
    input wire logic pump_switch_enable_bit_in,
    input wire logic core_supply_ok_in,
    input wire logic io_supply_ok_in,
    input wire logic ext_reset_n_in,
    input wire logic addr_switch_pin_in,
    input wire logic rx_ready_in,
    output logic data_plus_pin_out,
    output logic data_plus_pin_oe_n_out,
    output logic zero_minus_pin_out,
    output logic zero_minus_pin_oe_n_out,
    output logic diff_receive_pin_out,
    output logic rx_valid_out,
    output logic rx_ready_out,
    output logic por_pulse_out,
    output logic [6:0] bus_address_out,
    output logic pump_switch_output_out,
    output logic pump_switch_output_oe_n_out,
    output logic tx_driver_enable_out,
    output logic bias_enable_out,
    output logic [2:0] pump_switch_dbg_out
);
    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic dp_s;
    logic dm_s;
    logic core_s;
    logic io_s;
    logic xrst_s;
    logic adr_s;

    sync_agree #(.IDLE_LEVEL(1'b0)) dp_sync_i (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .async_in(dp_in),
        .level_out(dp_s)
    );

    sync_agree #(.IDLE_LEVEL(1'b0)) dm_sync_i (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .async_in(dm_in),
        .level_out(dm_s)
    );

    sync_agree #(.IDLE_LEVEL(1'b0)) core_sync_i (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .async_in(core_supply_ok_in),
        .level_out(core_s)
    );

    sync_agree #(.IDLE_LEVEL(1'b0)) io_sync_i (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .async_in(io_supply_ok_in),
        .level_out(io_s)
    );

    // Reset pin idles high; a low start would fake a rising edge
    sync_agree #(.IDLE_LEVEL(1'b1)) xrst_sync_i (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .async_in(ext_reset_n_in),
        .level_out(xrst_s)
    );

    sync_agree #(.IDLE_LEVEL(1'b0)) adr_sync_i (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .async_in(addr_switch_pin_in),
        .level_out(adr_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Power-on reset pulse with dip filter
    typedef enum logic [3:0] {
        POR_OFF = 4'b0001,
        POR_PULSE = 4'b0010,
        POR_RUN = 4'b0100,
        POR_DIP = 4'b1000
    } por_state_type;

    por_state_type por_state;
    por_state_type next_por_state;
    logic [otg_rx_pkg::CNT_W-1:0] por_cnt;
    logic [otg_rx_pkg::CNT_W-1:0] next_por_cnt;

    wire [otg_rx_pkg::CNT_W-1:0] pulse_last = 9'(otg_rx_pkg::RESET_PULSE_CYCLES - 1);
    wire [otg_rx_pkg::CNT_W-1:0] dip_last = 9'(otg_rx_pkg::DIP_CYCLES);

    always_comb begin
        next_por_state = por_state;
        next_por_cnt = por_cnt;
        unique case (por_state)
            POR_OFF: begin
                next_por_cnt = otg_rx_pkg::CNT_ZERO;
                if (core_s) next_por_state = POR_PULSE;
            end
            POR_PULSE: begin
                next_por_cnt = por_cnt + otg_rx_pkg::CNT_ONE;
                if (por_cnt >= pulse_last) begin
                    next_por_state = POR_RUN;
                    next_por_cnt = otg_rx_pkg::CNT_ZERO;
                end
            end
            POR_RUN: begin
                next_por_cnt = otg_rx_pkg::CNT_ZERO;
                if (!core_s) next_por_state = POR_DIP;
            end
            POR_DIP: begin
                next_por_cnt = por_cnt + otg_rx_pkg::CNT_ONE;
                if (core_s) begin
                    // Short dip ignored, long dip restarts the pulse
                    next_por_state = (por_cnt > dip_last) ? POR_PULSE : POR_RUN;
                    next_por_cnt = otg_rx_pkg::CNT_ZERO;
                end else if (por_cnt > dip_last) begin
                    next_por_cnt = por_cnt;
                end
            end
            default: begin
                next_por_state = POR_OFF;
                next_por_cnt = otg_rx_pkg::CNT_ZERO;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            por_state <= POR_OFF;
            por_cnt <= otg_rx_pkg::CNT_ZERO;
        end else begin
            por_state <= next_por_state;
            por_cnt <= next_por_cnt;
        end
    end

    wire por_active = (por_state == POR_PULSE);

    ////////////////////////////////////////////////////////////////////////////
    // Address bit latch and pump switch
    logic addr_bit;
    logic xrst_prev;
    wire xrst_rise = xrst_s & ~xrst_prev;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            addr_bit <= otg_rx_pkg::ADDR_BIT_RESET;
            xrst_prev <= 1'b1;
        end else begin
            xrst_prev <= xrst_s;
            // Power-on reset wins over a latch in the same cycle
            if (por_active) addr_bit <= otg_rx_pkg::ADDR_BIT_RESET;
            else if (xrst_rise) addr_bit <= adr_s;
        end
    end

    wire core_up = core_s & ~por_active;
    wire io_up = io_s;
    wire full_run = core_up & io_up & ~power_down_bit_in;
    wire pump_level = ~addr_bit;
    wire pump_drive = pump_switch_enable_bit_in & core_up & io_up;

    ////////////////////////////////////////////////////////////////////////////
    // Receive decoding
    wire line_j = dp_s & ~dm_s;
    wire line_k = ~dp_s & dm_s;
    wire line_jk = line_j | line_k;
    wire line_se0 = ~dp_s & ~dm_s;
    wire rx_enabled = output_enable_in & ~suspend_bit_in & full_run;
    logic rcv_hold;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rcv_hold <= otg_rx_pkg::HOLD_RESET;
        end else if (rx_enabled && line_jk) begin
            rcv_hold <= dp_s;
        end
    end

    wire next_rcv = line_jk ? dp_s : rcv_hold;
    wire next_data_single = suspend_bit_in ? dp_s : next_rcv;
    wire next_data = single_data_mode_bit_in ? next_data_single : dp_s;
    wire next_zero = single_data_mode_bit_in ? line_se0 : dm_s;

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry output buffer {data, zero, receive}
    logic [2:0] buf_mem [0:1];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] buf_cnt;
    wire pins_on = output_enable_in & core_up & io_up;
    wire [2:0] rx_word = {next_data, next_zero, next_rcv};
    wire buf_in_valid = pins_on;
    wire buf_full = (buf_cnt == 2'(otg_rx_pkg::BUF_DEPTH));
    wire buf_empty = (buf_cnt == 2'h0);
    wire push = buf_in_valid & ~buf_full;
    wire pop = rx_ready_in & ~buf_empty;
    wire [2:0] buf_head = buf_mem[rd_ptr];

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            buf_cnt <= 2'h0;
            buf_mem[0] <= 3'h0;
            buf_mem[1] <= 3'h0;
        end else begin
            if (push) buf_mem[wr_ptr] <= rx_word;
            if (push) wr_ptr <= ~wr_ptr;
            if (pop) rd_ptr <= ~rd_ptr;
            buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive pins move only when a word is taken; isolate also drives the receive pin low
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            data_plus_pin_out <= 1'b0;
            zero_minus_pin_out <= 1'b0;
            diff_receive_pin_out <= 1'b0;
        end else begin
            if (pop) data_plus_pin_out <= buf_head[2];
            if (pop) zero_minus_pin_out <= buf_head[1];
            // Isolate drives the receive pin low
            if (!core_s) diff_receive_pin_out <= 1'b0;
            else if (pop) diff_receive_pin_out <= buf_head[0];
        end
    end

    // Status outputs follow their sources one cycle late
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pump_switch_output_out <= 1'b0;
            por_pulse_out <= 1'b0;
        end else begin
            pump_switch_output_out <= pump_level;
            por_pulse_out <= por_active;
        end
    end

    assign rx_valid_out = ~buf_empty;
    assign rx_ready_out = ~buf_full;
    assign data_plus_pin_oe_n_out = ~pins_on;
    assign zero_minus_pin_oe_n_out = ~pins_on;
    assign pump_switch_output_oe_n_out = ~pump_drive;
    assign bus_address_out = otg_rx_pkg::BUS_ADDR_BASE | {6'h00, addr_bit};
    assign tx_driver_enable_out = full_run & ~output_enable_in;
    assign bias_enable_out = full_run;
    assign pump_switch_dbg_out = {pump_drive, pump_level, addr_bit};
endmodule // otg_rx_power

////////////////////////////////////////////////////////////////////////////////
// Three-flop synchroniser; a change counts once stages two and three agree
module sync_agree #(
    parameter logic IDLE_LEVEL = 1'b0
) (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic async_in,
    output logic level_out
);
    logic [2:0] stages;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stages <= {3{IDLE_LEVEL}};
            level_out <= IDLE_LEVEL;
        end else begin
            stages <= {stages[1:0], async_in};
            if (stages[1] == stages[2]) level_out <= stages[2];
        end
    end
endmodule // sync_agree

// ### tb/ctrl_model.sv
// Controller model: holds receive direction unless asked to transmit, consumes words.
// Runs on the bench clock; stalls on request.
`timescale 1ns/1ns
module ctrl_model (
    input wire logic sys_clk_in,
    input wire logic stall_in,
    input wire logic transmit_in,
    output logic rx_dir_out,
    output logic take_out
);
    initial rx_dir_out = 1'b1;
    initial take_out = 1'b0;
    // Requests seen at the edge take effect just after it
    always @(posedge sys_clk_in) begin
        take_out <= #2 !stall_in;
        rx_dir_out <= #2 !transmit_in;
    end
endmodule // ctrl_model

// ### tb/otg_rx_power_chk.sv
// Port checker for the receive and power block.
// Bound to every otg_rx_power instance; sees its ports only.
`timescale 1ns/1ns
module otg_rx_power_chk (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic output_enable_in,
    input wire logic power_down_bit_in,
    input wire logic pump_switch_enable_bit_in,
    input wire logic core_supply_ok_in,
    input wire logic io_supply_ok_in,
    input wire logic rx_ready_in,
    input wire logic data_plus_pin_out,
    input wire logic zero_minus_pin_out,
    input wire logic pump_switch_output_out,
    input wire logic data_plus_pin_oe_n_out,
    input wire logic zero_minus_pin_oe_n_out,
    input wire logic rx_valid_out,
    input wire logic rx_ready_out,
    input wire logic por_pulse_out,
    input wire logic [6:0] bus_address_out,
    input wire logic pump_switch_output_oe_n_out,
    input wire logic tx_driver_enable_out,
    input wire logic bias_enable_out,
    input wire logic [2:0] pump_switch_dbg_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    property p_base; bus_address_out[6:1] == otg_rx_pkg::BUS_ADDR_BASE[6:1]; endproperty
    a_base: assert property (p_base) else $error("address base wrong");
    property p_dbg;
        $past(rstn_in) |-> pump_switch_output_out == !$past(pump_switch_dbg_out[0]);
    endproperty
    a_dbg: assert property (p_dbg) else $error("pump polarity wrong");
    property p_por; $rose(por_pulse_out) |-> por_pulse_out [*5] ##1 !por_pulse_out; endproperty
    a_por: assert property (p_por) else $error("reset pulse width wrong");
    property p_clr; por_pulse_out ##1 por_pulse_out |-> !bus_address_out[0]; endproperty
    a_clr: assert property (p_clr) else $error("address bit not cleared");
    property p_buf;
        !rx_ready_in |=> $stable(data_plus_pin_out) && $stable(zero_minus_pin_out);
    endproperty
    a_buf: assert property (p_buf) else $error("pins moved while stalled");
    property p_dir; !data_plus_pin_oe_n_out |-> output_enable_in; endproperty
    a_dir: assert property (p_dir) else $error("data pin driven wrong way");
    property p_psw; !pump_switch_enable_bit_in [*6] |-> pump_switch_output_oe_n_out; endproperty
    a_psw: assert property (p_psw) else $error("pump switch driven");
    property p_pd; power_down_bit_in [*6] |-> !bias_enable_out; endproperty
    a_pd: assert property (p_pd) else $error("bias on in power down");
    property p_io; !io_supply_ok_in [*6] |-> !tx_driver_enable_out; endproperty
    a_io: assert property (p_io) else $error("driver on without io supply");
    property p_iso; !core_supply_ok_in [*6] |-> data_plus_pin_oe_n_out; endproperty
    a_iso: assert property (p_iso) else $error("pin driven without core");
endmodule // otg_rx_power_chk
bind otg_rx_power otg_rx_power_chk chk_i (.*);

// ### tb/tb.sv
// Bench for the receive and power block.
// Uses ctrl_model on the controller side; checker is bound.
`timescale 1ns/1ns
module tb;
    logic sys_clk_in = 1'b0, rstn_in = 1'b0, dp = 1'b1, dm = 1'b0, susp = 1'b0, sd = 1'b1;
    logic pd = 1'b0, pen = 1'b0, core = 1'b0, io = 1'b0, extn = 1'b1, adr = 1'b0, stall = 1'b0;
    logic dir, take, dat, dat_oe_n, zm, zm_oe_n, diff_receive_pin, vld, rdy, por, pump_switch_output, pump_switch_enable_bit_n, txe, bias;
    logic tx = 1'b0;
    logic [6:0] addr;
    int n_fail = 0, check_count = 0;
    always #20 sys_clk_in = !sys_clk_in;
    ctrl_model partner (.sys_clk_in(sys_clk_in), .stall_in(stall), .transmit_in(tx),
        .rx_dir_out(dir), .take_out(take));
    otg_rx_power uut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .dp_in(dp), .dm_in(dm),
        .output_enable_in(dir), .suspend_bit_in(susp), .single_data_mode_bit_in(sd),
        .power_down_bit_in(pd), .pump_switch_enable_bit_in(pen), .core_supply_ok_in(core),
        .io_supply_ok_in(io), .ext_reset_n_in(extn), .addr_switch_pin_in(adr),
        .rx_ready_in(take), .data_plus_pin_out(dat), .data_plus_pin_oe_n_out(dat_oe_n),
        .zero_minus_pin_out(zm), .zero_minus_pin_oe_n_out(zm_oe_n),
        .diff_receive_pin_out(diff_receive_pin), .rx_valid_out(vld), .rx_ready_out(rdy),
        .por_pulse_out(por), .bus_address_out(addr), .pump_switch_output_out(pump_switch_output),
        .pump_switch_output_oe_n_out(pump_switch_enable_bit_n), .tx_driver_enable_out(txe),
        .bias_enable_out(bias), .pump_switch_dbg_out());
    task automatic chk(input string what, input logic [6:0] seen, input logic [6:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_in);
        #2;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic watch_por(output logic seen);
        seen = 1'b0;
        repeat (40) begin
            step(1);
            seen = seen | (por === 1'b1);
        end
    endtask
    task automatic t_por;
        int w;
        core = 1'b1;
        io = 1'b1;
        w = 0;
        while (por !== 1'b1 && w < 50) begin
            step(1);
            w++;
        end
        chk("por", por, 7'h01);
        w = 0;
        while (por === 1'b1 && w < 50) begin
            step(1);
            w++;
        end
        chk("width", 7'(w), 7'(otg_rx_pkg::RESET_PULSE_CYCLES));
        pen = 1'b1;
        step(10);
        chk("addr", addr, 7'h2C);
        chk("psw", pump_switch_output, 7'h01);
        chk("pump_switch_enable_bit", pump_switch_enable_bit_n, 7'h00);
    endtask
    task automatic t_dip;
        logic s;
        core = 1'b0;
        step(100);
        core = 1'b1;
        watch_por(s);
        chk("short dip", s, 7'h00);
        core = 1'b0;
        step(300);
        core = 1'b1;
        watch_por(s);
        chk("long dip", s, 7'h01);
    endtask
    task automatic t_addr;
        for (int i = 1; i >= 0; i--) begin
            extn = 1'b0;
            adr = i[0];
            step(4);
            extn = 1'b1;
            step(10);
            chk("addr", addr, 7'h2C | 7'(i));
            chk("psw", pump_switch_output, 7'(!i[0]));
        end
        pen = 1'b0;
        step(10);
        chk("pump_switch_enable_bit", pump_switch_enable_bit_n, 7'h01);
    endtask
    task automatic t_lines;
        logic [1:0] st [4];
        logic h;
        st = '{2'b10, 2'b00, 2'b01, 2'b11};
        h = 1'b0;
        for (int m = 0; m < 4; m++) begin
            sd = !m[0];
            susp = m[1];
            for (int i = 0; i < 4; i++) begin
                {dp, dm} = st[i];
                step(14);
                if (!susp && dp != dm) h = dp;
                if (!susp) chk("rcv", diff_receive_pin, 7'(h));
                chk("dat", dat, 7'((susp || !sd || dp != dm) ? dp : h));
                chk("zm", zm, 7'(sd ? (!dp && !dm) : dm));
            end
        end
        susp = 1'b0;
        sd = 1'b1;
    endtask
    task automatic t_stall;
        {dp, dm} = 2'b10;
        step(14);
        stall = 1'b1;
        {dp, dm} = 2'b01;
        step(14);
        chk("full", {vld, rdy}, 7'h02);
        chk("held", dat, 7'h01);
        stall = 1'b0;
        step(14);
        chk("drained", {dat, zm}, 7'h00);
    endtask
    task automatic t_power;
        {dp, dm} = 2'b10;
        pd = 1'b1;
        step(8);
        chk("bias off", bias, 7'h00);
        pd = 1'b0;
        step(8);
        chk("bias on", bias, 7'h01);
        tx = 1'b1;
        step(4);
        chk("driver on", txe, 7'h01);
        io = 1'b0;
        step(8);
        chk("driver", txe, 7'h00);
        tx = 1'b0;
        io = 1'b1;
        step(8);
        chk("rcv before isolate", diff_receive_pin, 7'h01);
        core = 1'b0;
        step(8);
        chk("isolate", {dat_oe_n, zm_oe_n}, 7'h03);
        chk("isolate rcv", diff_receive_pin, 7'h00);
        core = 1'b1;
    endtask
    initial begin
        #2_000_000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        step(20);
        rstn_in = 1'b1;
        t_por();
        t_dip();
        t_addr();
        t_lines();
        t_stall();
        t_power();
        tally_and_finish();
    end
endmodule // tb
